/* File: pkg/pif_pkg.sv */
// Package for the peripheral interrupt flag block: offsets, layouts, reset values
package pif_pkg;
    // ------------------------------------------------------------------
    // Register word addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] PIF_OFF_FLAGS_A = 8'h00;
    localparam logic [7:0] PIF_OFF_FLAGS_B = 8'h04;
    localparam logic [7:0] PIF_OFF_ENA_A = 8'h08;
    localparam logic [7:0] PIF_OFF_ENA_B = 8'h0c;
    localparam logic [7:0] PIF_OFF_CTRL = 8'h10;
    localparam logic [7:0] PIF_OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] PIF_OFF_IRQ_MASK = 8'h18;
    localparam logic [7:0] PIF_OFF_ID = 8'h1c;
    // ------------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------------
    localparam int PIF_W = 8;
    localparam int PIF_RX_BIT = 5;
    localparam int PIF_TX_BIT = 4;
    localparam int PIF_OSC_BIT = 7;
    localparam int PIF_CMP2_BIT = 6;
    localparam int PIF_NVM_BIT = 4;
    localparam int PIF_BCL_BIT = 3;
    localparam int PIF_GIE_BIT = 7;
    localparam int PIF_PERIPHERAL_IRQ_ENABLE_BIT = 6;
    // Software-writable bits of each flag register
    localparam logic [7:0] PIF_WMASK_A = 8'hcf;
    localparam logic [7:0] PIF_IMPL_B_BIG = 8'hf8;
    localparam logic [7:0] PIF_IMPL_B_SMALL = 8'hb8;
    localparam logic [7:0] PIF_CTRL_MASK = 8'hc0;
    localparam logic [7:0] PIF_RST8 = 8'h00;
    localparam logic [31:0] PIF_RST32 = 32'h0000_0000;
    // Interrupt status bits: request rose, flag A set, flag B set
    localparam int PIF_IS_W = 3;
    localparam int PIF_IS_REQ = 0;
    localparam int PIF_IS_A = 1;
    localparam int PIF_IS_B = 2;
    // AXI responses
    localparam logic [1:0] PIF_RESP_OKAY = 2'h0;
    localparam logic [1:0] PIF_RESP_SLVERR = 2'h2;
    // Arbitrary identification value
    localparam logic [31:0] PIF_ID_VALUE = 32'h0000_5a01;
endpackage : pif_pkg

/* File: hdl/pif_flag_bank.sv */
// One bank of eight sticky request flags with set-over-clear priority
`timescale 1ns/1ps
`default_nettype none
module pif_flag_bank
    import pif_pkg::*;
(
    input wire logic clk_i, // System clock
    input wire logic srst_i, // Synchronous reset
    input wire logic [7:0] impl_i, // Implemented bit mask
    input wire logic [7:0] wmask_i, // Software-writable bits
    input wire logic [7:0] set_i, // Condition pulses
    input wire logic wr_i, // Software write strobe
    input wire logic [7:0] wdata_i, // Software write data
    output logic [7:0] flags_o // Flag state
);
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;

    // Next value per bit
    genvar g;
    for (g = 0; g < PIF_W; g++)
    begin : g_bit
        always_comb
        begin
            flags_nxt[g] = flags_r[g];
            if (wr_i && wmask_i[g])
                flags_nxt[g] = wdata_i[g];
            if (set_i[g])
                flags_nxt[g] = 1'b1;
            if (!impl_i[g])
                flags_nxt[g] = 1'b0;
        end
    end

    // Flag storage
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            flags_r <= PIF_RST8;
        else
            flags_r <= flags_nxt;
    end

    assign flags_o = flags_r;

    property p_set_wins;
        @(posedge clk_i) disable iff (srst_i)
        (set_i & impl_i) != PIF_RST8 |=> ((flags_r & $past(set_i & impl_i)) == $past(set_i & impl_i));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flag set lost");
endmodule : pif_flag_bank
`default_nettype wire

/* File: hdl/pif_top.sv */
// Peripheral interrupt flag block with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Each flag sets on its condition regardless of its enable or the global enable.
// - Flag register A holds timer1 gate, adc, rx, tx, sync serial, capture, timer2, timer1 bits 7..0.
// - A flag reads 1 while pending and 0 otherwise.
// - Writable flags are read/write and every flag resets to 0.
// - Flag register B holds osc fail, comparator 2, comparator 1, nvm done, bus collision in bits 7..3.
// - Bits 2..0 of flag register B read zero and ignore writes.
// - The comparator 2 flag exists only on the larger variant.
// - B bit 4 sets when a nonvolatile memory write completes.
// - B bit 7 sets when the clock monitor detects oscillator failure.
// - B bit 3 sets when the sync serial port sees a bus collision.
// - No peripheral interrupt reaches the core unless the peripheral enable is set.
// - A cleared global enable blocks the request to the core; the masked status interrupt irq_o is not gated by it.
module pif_top
    import pif_pkg::*;
#(
    parameter bit HAS_CMP2 = 1'b1 // Larger variant with comparator 2
)
(
    input wire logic clk_i, // 40 MHz system clock
    input wire logic srst_i, // Synchronous reset, active high
    input wire logic [7:0] cond_a_i, // Condition pulses, register A layout
    input wire logic osc_fail_i, // Clock monitor failure pulse
    input wire logic cmp2_i, // Comparator 2 pulse
    input wire logic cmp1_i, // Comparator 1 pulse
    input wire logic nvm_done_i, // Nonvolatile write complete pulse
    input wire logic bus_coll_i, // Bus collision pulse
    input wire logic [7:0] awaddr_i, // AXI write address
    input wire logic awvalid_i, // AXI write address valid
    output logic awready_o, // AXI write address ready
    input wire logic [31:0] wdata_i, // AXI write data
    input wire logic [3:0] wstrb_i, // AXI write strobes
    input wire logic wvalid_i, // AXI write data valid
    output logic wready_o, // AXI write data ready
    output logic [1:0] bresp_o, // AXI write response
    output logic bvalid_o, // AXI write response valid
    input wire logic bready_i, // AXI write response ready
    input wire logic [7:0] araddr_i, // AXI read address
    input wire logic arvalid_i, // AXI read address valid
    output logic arready_o, // AXI read address ready
    output logic [31:0] rdata_o, // AXI read data
    output logic [1:0] rresp_o, // AXI read response
    output logic rvalid_o, // AXI read valid
    input wire logic rready_i, // AXI read ready
    output logic core_irq_o, // Peripheral request to the core
    output logic irq_o // Masked status interrupt
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0] flags_a;
    logic [7:0] flags_b;
    logic [7:0] set_b;
    logic [7:0] impl_b;
    logic [7:0] ena_a_r;
    logic [7:0] ena_b_r;
    logic [7:0] ctrl_r;
    logic [PIF_IS_W-1:0] istat_r;
    logic [PIF_IS_W-1:0] imask_r;
    logic [7:0] aw_addr_r;
    logic aw_have_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic w_have_r;
    logic wr_fire;
    logic wr_ok;
    logic rd_fire;
    logic req_now;
    logic req_prev_r;
    logic [PIF_IS_W-1:0] ev;
    logic [31:0] rd_word;
    logic rd_ok;

    // Decode a word address to a known register
    function automatic logic addr_known(input logic [7:0] a);
        return (a == PIF_OFF_FLAGS_A) || (a == PIF_OFF_FLAGS_B) || (a == PIF_OFF_ENA_A) ||
               (a == PIF_OFF_ENA_B) || (a == PIF_OFF_CTRL) || (a == PIF_OFF_IRQ_STAT) ||
               (a == PIF_OFF_IRQ_MASK) || (a == PIF_OFF_ID);
    endfunction : addr_known

    // Write to one register with the low byte lane enabled
    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off,
                                    input logic fire, input logic [3:0] strb);
        return fire && (a == off) && strb[0];
    endfunction : wr_hit

    // ------------------------------------------------------------------
    // AXI write channel: address and data caught independently
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            aw_have_r <= 1'b0;
            aw_addr_r <= PIF_RST8;
            awready_o <= 1'b0;
        end
        else
        begin
            awready_o <= !aw_have_r && !awready_o && !bvalid_o;
            if (awvalid_i && awready_o)
            begin
                aw_have_r <= 1'b1;
                aw_addr_r <= awaddr_i;
                awready_o <= 1'b0;
            end
            else if (wr_fire)
                aw_have_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            w_have_r <= 1'b0;
            w_data_r <= PIF_RST32;
            w_strb_r <= 4'h0;
            wready_o <= 1'b0;
        end
        else
        begin
            wready_o <= !w_have_r && !wready_o && !bvalid_o;
            if (wvalid_i && wready_o)
            begin
                w_have_r <= 1'b1;
                w_data_r <= wdata_i;
                w_strb_r <= wstrb_i;
                wready_o <= 1'b0;
            end
            else if (wr_fire)
                w_have_r <= 1'b0;
        end
    end

    assign wr_fire = aw_have_r && w_have_r && !bvalid_o;
    assign wr_ok = addr_known(aw_addr_r);

    // Write response
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            bvalid_o <= 1'b0;
            bresp_o <= PIF_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_o <= 1'b1;
            bresp_o <= wr_ok ? PIF_RESP_OKAY : PIF_RESP_SLVERR;
        end
        else if (bready_i)
            bvalid_o <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Flag banks
    // ------------------------------------------------------------------
    // Register B conditions placed at their bit positions
    always_comb
    begin
        set_b = PIF_RST8;
        set_b[PIF_OSC_BIT] = osc_fail_i;
        set_b[PIF_CMP2_BIT] = cmp2_i;
        set_b[PIF_NVM_BIT] = nvm_done_i;
        set_b[PIF_BCL_BIT] = bus_coll_i;
        set_b[PIF_CMP2_BIT - 1] = cmp1_i;
    end

    assign impl_b = HAS_CMP2 ? PIF_IMPL_B_BIG : PIF_IMPL_B_SMALL;

    pif_flag_bank u_bank_a (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .impl_i(8'hff),
        .wmask_i(PIF_WMASK_A),
        .set_i(cond_a_i),
        .wr_i(wr_hit(aw_addr_r, PIF_OFF_FLAGS_A, wr_fire, w_strb_r)),
        .wdata_i(w_data_r[7:0]),
        .flags_o(flags_a)
    );

    pif_flag_bank u_bank_b (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .impl_i(impl_b),
        .wmask_i(impl_b),
        .set_i(set_b),
        .wr_i(wr_hit(aw_addr_r, PIF_OFF_FLAGS_B, wr_fire, w_strb_r)),
        .wdata_i(w_data_r[7:0]),
        .flags_o(flags_b)
    );

    // ------------------------------------------------------------------
    // Enable and control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            ena_a_r <= PIF_RST8;
            ena_b_r <= PIF_RST8;
            ctrl_r <= PIF_RST8;
            imask_r <= '0;
        end
        else
        begin
            if (wr_hit(aw_addr_r, PIF_OFF_ENA_A, wr_fire, w_strb_r))
                ena_a_r <= w_data_r[7:0];
            if (wr_hit(aw_addr_r, PIF_OFF_ENA_B, wr_fire, w_strb_r))
                ena_b_r <= w_data_r[7:0] & impl_b;
            if (wr_hit(aw_addr_r, PIF_OFF_CTRL, wr_fire, w_strb_r))
                ctrl_r <= w_data_r[7:0] & PIF_CTRL_MASK;
            if (wr_hit(aw_addr_r, PIF_OFF_IRQ_MASK, wr_fire, w_strb_r))
                imask_r <= w_data_r[PIF_IS_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Request to the core
    // ------------------------------------------------------------------
    assign req_now = (|(flags_a & ena_a_r) || |(flags_b & ena_b_r))
                     && ctrl_r[PIF_PERIPHERAL_IRQ_ENABLE_BIT]
                     && ctrl_r[PIF_GIE_BIT];

    // Registered request output
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            core_irq_o <= 1'b0;
            req_prev_r <= 1'b0;
        end
        else
        begin
            core_irq_o <= req_now;
            req_prev_r <= req_now;
        end
    end

    // ------------------------------------------------------------------
    // Sticky status, cleared by read, set wins
    // ------------------------------------------------------------------
    assign ev[PIF_IS_REQ] = req_now && !req_prev_r;
    assign ev[PIF_IS_A] = |cond_a_i;
    assign ev[PIF_IS_B] = |(set_b & impl_b);

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            istat_r <= '0;
            irq_o <= 1'b0;
        end
        else
        begin
            if (rd_fire && araddr_i == PIF_OFF_IRQ_STAT)
                istat_r <= ev;
            else
                istat_r <= istat_r | ev;
            irq_o <= |(istat_r & imask_r);
        end
    end

    // ------------------------------------------------------------------
    // AXI read channel
    // ------------------------------------------------------------------
    assign rd_fire = arvalid_i && arready_o;

    always_comb
    begin
        rd_word = PIF_RST32;
        rd_ok = addr_known(araddr_i);
        unique case (araddr_i)
            PIF_OFF_FLAGS_A: rd_word[7:0] = flags_a;
            PIF_OFF_FLAGS_B: rd_word[7:0] = flags_b;
            PIF_OFF_ENA_A: rd_word[7:0] = ena_a_r;
            PIF_OFF_ENA_B: rd_word[7:0] = ena_b_r;
            PIF_OFF_CTRL: rd_word[7:0] = ctrl_r;
            PIF_OFF_IRQ_STAT: rd_word[PIF_IS_W-1:0] = istat_r;
            PIF_OFF_IRQ_MASK: rd_word[PIF_IS_W-1:0] = imask_r;
            PIF_OFF_ID: rd_word = PIF_ID_VALUE;
            default: rd_word = PIF_RST32;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            arready_o <= 1'b0;
            rvalid_o <= 1'b0;
            rdata_o <= PIF_RST32;
            rresp_o <= PIF_RESP_OKAY;
        end
        else
        begin
            arready_o <= !rvalid_o && !arready_o;
            if (rd_fire)
            begin
                arready_o <= 1'b0;
                rvalid_o <= 1'b1;
                rdata_o <= rd_word;
                rresp_o <= rd_ok ? PIF_RESP_OKAY : PIF_RESP_SLVERR;
            end
            else if (rvalid_o && rready_i)
                rvalid_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_flag_set;
        @(posedge clk_i) disable iff (srst_i)
        cond_a_i[0] |=> flags_a[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag A0 not set");

    property p_rx_ro;
        @(posedge clk_i) disable iff (srst_i)
        !cond_a_i[PIF_RX_BIT] |=> flags_a[PIF_RX_BIT] == $past(flags_a[PIF_RX_BIT]) || $past(srst_i);
    endproperty
    a_rx_ro: assert property (p_rx_ro) else $error("rx flag changed by write");

    property p_tx_ro;
        @(posedge clk_i) disable iff (srst_i)
        !cond_a_i[PIF_TX_BIT] |=> flags_a[PIF_TX_BIT] == $past(flags_a[PIF_TX_BIT]);
    endproperty
    a_tx_ro: assert property (p_tx_ro) else $error("tx flag changed by write");

    property p_unimpl_zero;
        @(posedge clk_i) disable iff (srst_i)
        flags_b[2:0] == 3'h0;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("B low bits set");

    property p_nvm;
        @(posedge clk_i) disable iff (srst_i)
        nvm_done_i |=> flags_b[PIF_NVM_BIT];
    endproperty
    a_nvm: assert property (p_nvm) else $error("nvm flag missed");

    property p_osc;
        @(posedge clk_i) disable iff (srst_i)
        osc_fail_i |=> flags_b[PIF_OSC_BIT];
    endproperty
    a_osc: assert property (p_osc) else $error("osc flag missed");

    property p_bcl;
        @(posedge clk_i) disable iff (srst_i)
        bus_coll_i |=> flags_b[PIF_BCL_BIT];
    endproperty
    a_bcl: assert property (p_bcl) else $error("collision flag missed");

    property p_gate;
        @(posedge clk_i) disable iff (srst_i)
        !(ctrl_r[PIF_PERIPHERAL_IRQ_ENABLE_BIT] && ctrl_r[PIF_GIE_BIT]) |=> !core_irq_o;
    endproperty
    a_gate: assert property (p_gate) else $error("request leaked past enables");

    property p_req;
        @(posedge clk_i) disable iff (srst_i)
        (|(flags_a & ena_a_r)) && ctrl_r[PIF_PERIPHERAL_IRQ_ENABLE_BIT] && ctrl_r[PIF_GIE_BIT] |=> core_irq_o;
    endproperty
    a_req: assert property (p_req) else $error("request missing");

    property p_reset_clear;
        @(posedge clk_i) srst_i |=> flags_a == PIF_RST8 && flags_b == PIF_RST8;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("flags not cleared");
endmodule : pif_top
`default_nettype wire

/* File: dv/pif_periph_model.sv */
// Model of the peripherals that raise interrupt conditions
`timescale 1ns/1ps
`default_nettype none
module pif_periph_model
(
    input wire logic clk_i, // System clock
    input wire logic srst_i, // Synchronous reset
    input wire logic fire_i, // Request one event pulse
    input wire logic hold_i, // Keep conditions high as a level
    input wire logic [1:0] dly_i, // Extra cycles before the pulse
    input wire logic [7:0] sel_a_i, // Events, register A layout
    input wire logic [4:0] sel_b_i, // Events, register B bits 7..3
    output logic [7:0] cond_a_o, // Condition lines, register A layout
    output logic [4:0] cond_b_o // Condition lines, register B bits 7..3
);
    // ------------------------------------------------------------------
    // Delay and pulse generation
    // ------------------------------------------------------------------
    logic busy_r;
    logic [1:0] cnt_r;
    logic go;
    assign go = (busy_r && cnt_r == 2'h0) || hold_i;
    // Delay state: a slow peripheral answers up to three cycles late
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            busy_r <= 1'b0;
        else if (fire_i)
            busy_r <= 1'b1;
        else if (cnt_r == 2'h0)
            busy_r <= 1'b0;
        if (srst_i)
            cnt_r <= 2'h0;
        else if (fire_i)
            cnt_r <= dly_i;
        else if (cnt_r != 2'h0)
            cnt_r <= cnt_r - 2'h1;
    end
    // One-cycle pulse, or a level while held
    always_ff @(posedge clk_i)
    begin
        cond_a_o <= go ? sel_a_i : 8'h00;
        cond_b_o <= go ? sel_b_i : 5'h00;
    end
endmodule : pif_periph_model
`default_nettype wire

/* File: dv/test_peripheral_interrupt_flags.sv */
// Self-checking bench for the peripheral interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module test_peripheral_interrupt_flags
    import pif_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0, strb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, core_irq, irq;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd, rdata_s;
    logic fire = 1'b0, hold = 1'b0;
    logic [1:0] dly = 2'h0;
    logic [7:0] sel_a = 8'h00;
    logic [4:0] sel_b = 5'h00;
    logic [7:0] cond_a;
    logic [4:0] cond_b;
    logic [7:0] exp_a = 8'h00, exp_b = 8'h00, ea, eb, ctl;
    int mismatches = 0;
    int check_count = 0;
    // Clock at 40 MHz
    always #12.5 clk = ~clk;
    pif_top #(.HAS_CMP2(1'b1)) u_pif_top (
        .clk_i(clk), .srst_i(srst), .cond_a_i(cond_a), .osc_fail_i(cond_b[4]),
        .cmp2_i(cond_b[3]), .cmp1_i(cond_b[2]), .nvm_done_i(cond_b[1]), .bus_coll_i(cond_b[0]),
        .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata),
        .wstrb_i(wstrb), .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp),
        .bvalid_o(bvalid), .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid),
        .arready_o(arready), .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid),
        .rready_i(rready), .core_irq_o(core_irq), .irq_o(irq));
    pif_periph_model u_pif_periph_model (
        .clk_i(clk), .srst_i(srst), .fire_i(fire), .hold_i(hold), .dly_i(dly),
        .sel_a_i(sel_a), .sel_b_i(sel_b), .cond_a_o(cond_a), .cond_b_o(cond_b));
    // Smaller variant
    pif_top #(.HAS_CMP2(1'b0)) u_pif_top_s (
        .clk_i(clk), .srst_i(srst), .cond_a_i(cond_a), .osc_fail_i(cond_b[4]),
        .cmp2_i(cond_b[3]), .cmp1_i(cond_b[2]), .nvm_done_i(cond_b[1]), .bus_coll_i(cond_b[0]),
        .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(), .wdata_i(wdata),
        .wstrb_i(wstrb), .wvalid_i(wvalid), .wready_o(), .bresp_o(), .bvalid_o(),
        .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(),
        .rdata_o(rdata_s), .rresp_o(), .rvalid_o(), .rready_i(rready), .core_irq_o(),
        .irq_o());
    // ------------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------------
    task automatic miss(input string what);
        mismatches++;
        $display("MISMATCH at %0t: %s", $time, what);
    endtask : miss
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp)
            miss($sformatf("%s got %h expected %h", what, got, exp));
    endtask : chk
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        bit aw_p;
        bit w_p;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_p = 1'b1;
        w_p = 1'b1;
        r = 2'h3;
        for (n = 0; n < 200; n++)
        begin
            @(posedge clk);
            if (bvalid)
            begin
                r = bresp;
                break;
            end
            if (aw_p && awready)
            begin
                awvalid <= 1'b0;
                aw_p = 1'b0;
            end
            if (w_p && wready)
            begin
                wvalid <= 1'b0;
                w_p = 1'b0;
            end
        end
        bready <= 1'b0;
        if (n == 200)
            miss("write hang");
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        bit ar_p;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        ar_p = 1'b1;
        r = 2'h3;
        d = 32'h0;
        for (n = 0; n < 200; n++)
        begin
            @(posedge clk);
            if (rvalid)
            begin
                r = rresp;
                d = rdata;
                break;
            end
            if (ar_p && arready)
            begin
                arvalid <= 1'b0;
                ar_p = 1'b0;
            end
        end
        rready <= 1'b0;
        if (n == 200)
            miss("read hang");
    endtask : axi_rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axi_wr(a, d, rs);
        chk({30'h0, rs}, {30'h0, PIF_RESP_OKAY}, "write resp");
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        axi_rd(a, rd, rs);
        chk(rd, e, $sformatf("read %h", a));
        chk({30'h0, rs}, {30'h0, PIF_RESP_OKAY}, "read resp");
    endtask : rd_chk
    // Wait for registered outputs
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle
    // One peripheral event, random delay
    task automatic ev(input logic [7:0] a, input logic [4:0] b);
        @(posedge clk);
        sel_a <= a;
        sel_b <= b;
        dly <= 2'($urandom_range(3, 0));
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        exp_a = exp_a | a;
        exp_b = exp_b | {b, 3'b000};
        repeat (5) @(posedge clk);
        settle();
    endtask : ev
    function automatic logic exp_core(input logic [7:0] fa, fb, na, nb, c);
        return (|(fa & na) || |(fb & nb)) && c[PIF_GIE_BIT] && c[PIF_PERIPHERAL_IRQ_ENABLE_BIT];
    endfunction : exp_core
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    // ------------------------------------------------------------------
    // Watchdog and main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (30000) @(posedge clk);
        miss("watchdog");
        report_and_stop();
    end
    initial
    begin
        void'($urandom(32'h715b));
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rd_chk(PIF_OFF_FLAGS_A, 32'h0);
        rd_chk(PIF_OFF_FLAGS_B, 32'h0);
        rd_chk(PIF_OFF_ID, PIF_ID_VALUE);
        wr(PIF_OFF_FLAGS_A, 32'hff);
        rd_chk(PIF_OFF_FLAGS_A, 32'hcf);
        wr(PIF_OFF_FLAGS_B, 32'hff);
        rd_chk(PIF_OFF_FLAGS_B, 32'hf8);
        wr(PIF_OFF_FLAGS_A, 32'h0);
        wr(PIF_OFF_FLAGS_B, 32'h0);
        // Every flag position on its own, enables all off
        for (int i = 0; i < 8; i++)
        begin
            wr(PIF_OFF_FLAGS_A, 32'h0);
            wr(PIF_OFF_FLAGS_B, 32'h0);
            exp_a = exp_a & ~PIF_WMASK_A;
            exp_b = 8'h00;
            ev(8'h01 << i, 5'(5'h01 << i));
            chk({31'h0, core_irq}, 32'h0, "core irq");
            rd_chk(PIF_OFF_FLAGS_A, {24'h0, exp_a});
            rd_chk(PIF_OFF_FLAGS_B, {24'h0, exp_b});
            chk(rdata_s, {24'h0, exp_b & PIF_IMPL_B_SMALL}, "small B");
        end
        // Random enables, control and events
        for (int k = 0; k < 16; k++)
        begin
            ea = 8'($urandom);
            eb = 8'($urandom) & PIF_IMPL_B_BIG;
            ctl = 8'($urandom);
            wr(PIF_OFF_FLAGS_A, 32'h0);
            wr(PIF_OFF_FLAGS_B, 32'h0);
            exp_a = exp_a & ~PIF_WMASK_A;
            exp_b = 8'h00;
            wr(PIF_OFF_ENA_A, {24'h0, ea});
            wr(PIF_OFF_ENA_B, {24'h0, eb | 8'($urandom_range(7, 0))});
            wr(PIF_OFF_CTRL, {24'h0, ctl});
            ctl = ctl & PIF_CTRL_MASK;
            rd_chk(PIF_OFF_ENA_B, {24'h0, eb});
            rd_chk(PIF_OFF_CTRL, {24'h0, ctl});
            settle();
            chk({31'h0, core_irq}, {31'h0, exp_core(exp_a, exp_b, ea, eb, ctl)}, "irq");
            ev(8'($urandom), 5'($urandom));
            chk({31'h0, core_irq}, {31'h0, exp_core(exp_a, exp_b, ea, eb, ctl)}, "irq");
            rd_chk(PIF_OFF_FLAGS_A, {24'h0, exp_a});
            rd_chk(PIF_OFF_FLAGS_B, {24'h0, exp_b});
        end
        // Condition held high across a clearing write
        sel_a <= 8'h01;
        hold <= 1'b1;
        wr(PIF_OFF_FLAGS_A, 32'h0);
        hold <= 1'b0;
        exp_a = (exp_a & ~PIF_WMASK_A) | 8'h01;
        rd_chk(PIF_OFF_FLAGS_A, {24'h0, exp_a});
        // Status, mask and interrupt line
        wr(PIF_OFF_CTRL, 32'h0);
        wr(PIF_OFF_IRQ_MASK, 32'h6);
        axi_rd(PIF_OFF_IRQ_STAT, rd, rs);
        ev(8'h04, 5'h00);
        chk({31'h0, irq}, 32'h1, "irq raised");
        rd_chk(PIF_OFF_IRQ_STAT, 32'h2);
        settle();
        chk({31'h0, irq}, 32'h0, "irq after clear");
        wr(PIF_OFF_IRQ_MASK, 32'h0);
        ev(8'h00, 5'h01);
        chk({31'h0, irq}, 32'h0, "irq masked");
        rd_chk(PIF_OFF_IRQ_STAT, 32'h4);
        wr(PIF_OFF_IRQ_MASK, 32'h1);
        wr(PIF_OFF_ENA_A, 32'hff);
        wr(PIF_OFF_CTRL, 32'hc0);
        settle();
        chk({31'h0, core_irq}, 32'h1, "core irq");
        chk({31'h0, irq}, 32'h1, "irq on core request");
        rd_chk(PIF_OFF_IRQ_STAT, 32'h1);
        strb = 4'h0;
        wr(PIF_OFF_ENA_A, 32'h0);
        strb = 4'hf;
        rd_chk(PIF_OFF_ENA_A, 32'hff);
        // Unmapped address
        axi_rd(8'h20, rd, rs);
        chk({30'h0, rs}, {30'h0, PIF_RESP_SLVERR}, "unmapped read");
        chk(rd, 32'h0, "unmapped data");
        axi_wr(8'h20, 32'hff, rs);
        chk({30'h0, rs}, {30'h0, PIF_RESP_SLVERR}, "unmapped write");
        // Second reset in mid-run
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd_chk(PIF_OFF_FLAGS_A, 32'h0);
        rd_chk(PIF_OFF_FLAGS_B, 32'h0);
        chk({31'h0, core_irq}, 32'h0, "core irq after reset");
        report_and_stop();
    end
endmodule : test_peripheral_interrupt_flags
`default_nettype wire
